/* verilog/freq_trip_curve_registers.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - unused low curves read zero except the flag, read-only
// - unused curve read-only flag reads one
// - offline within 100 ms after duration
// - working copy refreshed only reset/select/enable
// - model length reads fixed 210
// - select zero uses default high threshold
// - durations in 0.01 s, scaled
// - frequencies in 0.01 Hz units
// - enable bit 0 gates curve use
module freq_trip_curve_registers
    import trip_curve_pkg::*;
#(
    parameter int TICK_CYCLES     = TICK_CYCLES_DEF,
    parameter int TRIP_MAX_CYCLES = TRIP_MAX_CYC_DEF
) (
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [17:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [15:0] FREQ_MEAS,
    output logic             OFFLINE
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    apb_state_type apb_q;
    logic [31:0]   prdata_q;
    logic          pready_q;
    logic          pslverr_q;
    logic [15:0]   sel_q;
    logic [15:0]   en_q;
    logic [15:0]   lf_dur_sf_q;
    logic [15:0]   hf_dur_sf_q;
    logic [15:0]   p1_dur_q;
    logic [15:0]   p1_freq_q;
    logic [15:0]   def_thr_q;
    logic          work_on_q;
    logic [15:0]   work_dur_q;
    logic [15:0]   work_freq_q;
    logic [31:0]   tick_cnt_q;
    logic [6:0]    decade_q;
    logic [15:0]   dur_cnt_q;
    logic          offline_q;
    logic [15:0]   idx;
    logic          wr_commit;
    logic          rd_phase;
    logic [15:0]   wdata;
    logic          rd_mapped;
    logic [15:0]   rd_data;
    logic          sel_wr;
    logic          en_wr;
    logic          work_on_d;
    logic          tick_10ms;
    logic [6:0]    decade_limit;
    logic          unit_tick;
    logic          out_of_range;
    logic          elapsed;
    logic          over_default;
    logic [31:0]   late_cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_unused_curve(input logic [15:0] i);
        is_unused_curve = (i >= UNUSED_FIRST) && (i <= UNUSED_LAST);
    endfunction

    function automatic logic is_unused_flag(input logic [15:0] i);
        logic hit;
        hit = 1'b0;
        for (int c = 0; c < UNUSED_CURVES; c++) begin
            if (i == UNUSED_FIRST + UNUSED_FLAG_OFS + 16'(c) * UNUSED_STRIDE) begin
                hit = 1'b1;
            end
        end
        is_unused_flag = hit;
    endfunction

    function automatic logic sf_legal(input logic [15:0] v);
        sf_legal = (v == SF_MINUS_2) || (v == SF_MINUS_1) || (v == SF_ZERO);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb slave

    assign idx       = PADDR[17:2];
    assign wdata     = PWDATA[15:0];
    assign rd_phase  = PSEL && PENABLE && (apb_q == APB_SETUP);
    assign wr_commit = PSEL && PENABLE && (apb_q == APB_ANSWER) && PWRITE && !pslverr_q;
    assign sel_wr    = wr_commit && (idx == IDX_HF_SEL) && (wdata <= VAL_READ_ONLY);
    assign en_wr     = wr_commit && (idx == IDX_HF_EN);

    always_comb begin
        rd_mapped = 1'b1;
        rd_data   = RST_ZERO;
        if (is_unused_curve(idx)) begin
            rd_data = is_unused_flag(idx) ? VAL_READ_ONLY : RST_ZERO;
        end else begin
            unique case (idx)
                IDX_LF_DUR_SF:  rd_data = lf_dur_sf_q;
                IDX_LF_FREQ_SF: rd_data = SF_MINUS_2;
                IDX_HF_ID:      rd_data = VAL_MODEL_ID;
                IDX_HF_LEN:     rd_data = VAL_MODEL_LEN;
                IDX_HF_SEL:     rd_data = sel_q;
                IDX_HF_EN:      rd_data = en_q;
                IDX_HF_DUR_SF:  rd_data = hf_dur_sf_q;
                IDX_HF_FREQ_SF: rd_data = SF_MINUS_2;
                IDX_HF_P1_DUR:  rd_data = p1_dur_q;
                IDX_HF_P1_FREQ: rd_data = p1_freq_q;
                IDX_HF_DEF_THR: rd_data = def_thr_q;
                default:        rd_mapped = 1'b0;
            endcase
        end
        if (PADDR[1:0] != 2'b00) begin
            rd_mapped = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            apb_q     <= APB_SETUP;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (rd_phase) begin
            apb_q     <= APB_ANSWER;
            pready_q  <= 1'b1;
            prdata_q  <= rd_mapped ? {16'h0000, rd_data} : 32'h0000_0000;
            pslverr_q <= !rd_mapped;
        end else begin
            apb_q     <= APB_SETUP;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable registers; read-only ones have no storage

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            sel_q       <= RST_SEL;
            en_q        <= RST_EN;
            lf_dur_sf_q <= SF_MINUS_2;
            hf_dur_sf_q <= SF_MINUS_2;
            p1_dur_q    <= RST_P1_DUR;
            p1_freq_q   <= RST_P1_FREQ;
            def_thr_q   <= RST_DEF_THR;
        end else if (wr_commit) begin
            if (sel_wr) begin
                sel_q <= wdata;
            end
            if (en_wr) begin
                en_q <= {15'h0000, wdata[EN_BIT]};
            end
            if (idx == IDX_LF_DUR_SF && sf_legal(wdata)) begin
                lf_dur_sf_q <= wdata;
            end
            if (idx == IDX_HF_DUR_SF && sf_legal(wdata)) begin
                hf_dur_sf_q <= wdata;
            end
            if (idx == IDX_HF_P1_DUR) begin
                p1_dur_q <= wdata;
            end
            if (idx == IDX_HF_P1_FREQ) begin
                p1_freq_q <= wdata;
            end
            if (idx == IDX_HF_DEF_THR) begin
                def_thr_q <= wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // working copy of the active curve

    always_comb begin
        work_on_d = work_on_q;
        if (sel_wr) begin
            work_on_d = (wdata == RST_SEL) && en_q[EN_BIT];
        end
        if (en_wr) begin
            work_on_d = (sel_q == RST_SEL) && wdata[EN_BIT];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            work_on_q   <= 1'b1;
            work_dur_q  <= RST_P1_DUR;
            work_freq_q <= RST_P1_FREQ;
        end else if (sel_wr || en_wr) begin
            work_on_q   <= work_on_d;
            work_dur_q  <= p1_dur_q;
            work_freq_q <= p1_freq_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ride-through timer

    assign out_of_range = FREQ_MEAS > work_freq_q;
    assign over_default = FREQ_MEAS > def_thr_q;
    assign tick_10ms    = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    assign unit_tick    = tick_10ms && (decade_q >= decade_limit - 7'h01);
    assign elapsed      = dur_cnt_q >= work_dur_q;

    always_comb begin
        unique case (hf_dur_sf_q)
            SF_MINUS_1: decade_limit = DEC_X10;
            SF_ZERO:    decade_limit = DEC_X100;
            default:    decade_limit = DEC_X1;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST || !out_of_range) begin
            tick_cnt_q <= 32'h0000_0000;
            decade_q   <= 7'h00;
        end else if (tick_10ms) begin
            tick_cnt_q <= 32'h0000_0000;
            decade_q   <= unit_tick ? 7'h00 : decade_q + 7'h01;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST || !out_of_range) begin
            dur_cnt_q <= 16'h0000;
        end else if (unit_tick && dur_cnt_q != 16'hFFFF) begin
            dur_cnt_q <= dur_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            offline_q <= 1'b0;
        end else if (work_on_q) begin
            offline_q <= out_of_range && elapsed;
        end else begin
            offline_q <= over_default;
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;
    assign OFFLINE = offline_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    always_ff @(posedge REF_CLK) begin
        if (!NRST || offline_q || !(work_on_q && out_of_range && elapsed)) begin
            late_cnt_q <= 32'h0000_0000;
        end else begin
            late_cnt_q <= late_cnt_q + 32'h0000_0001;
        end
    end

    a_unused_reads_zero: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        rd_phase && PADDR[1:0] == 2'b00 && is_unused_curve(idx) && !is_unused_flag(idx)
        |=> PREADY && PRDATA == 32'h0000_0000 && !PSLVERR)
        else $error("unused curve register read nonzero");

    a_flag_reads_one: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        rd_phase && PADDR[1:0] == 2'b00 && is_unused_flag(idx)
        |=> PRDATA == 32'h0000_0001)
        else $error("read-only flag not one");

    a_trip_on_elapse: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        work_on_q && out_of_range && elapsed |=> OFFLINE)
        else $error("no trip after duration elapsed");

    a_trip_max_delay: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        late_cnt_q < 32'(TRIP_MAX_CYCLES))
        else $error("trip delay exceeded limit");

    a_refresh_only_cmd: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        !$past(sel_wr) && !$past(en_wr) && $past(NRST)
        |-> $stable(work_freq_q) && $stable(work_dur_q) && $stable(work_on_q))
        else $error("working curve changed without refresh");

    a_length_fixed: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        rd_phase && PADDR[1:0] == 2'b00 && idx == IDX_HF_LEN
        |=> PRDATA[15:0] == 16'h00D2)
        else $error("model length wrong");

    a_default_threshold: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        sel_q == 16'h0000 && !sel_wr && !en_wr ##1 $stable(def_thr_q)
        |-> OFFLINE == $past(FREQ_MEAS > def_thr_q))
        else $error("default threshold not applied");

    a_select_legal: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        sel_q <= RST_SEL)
        else $error("active curve select out of range");

    a_dur_unit_tick: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        hf_dur_sf_q == SF_MINUS_2 |-> unit_tick == tick_10ms)
        else $error("unit tick not 10 ms at default scale");

    a_freq_in_range: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        work_on_q && !sel_wr && !en_wr && FREQ_MEAS <= work_freq_q |=> !OFFLINE)
        else $error("trip while frequency in range");

    a_enable_clears: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        en_wr && !wdata[EN_BIT] |=> !work_on_q ##0 en_q == 16'h0000)
        else $error("disable did not drop curve");

    a_ro_unchanged: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        wr_commit && is_unused_curve(idx)
        |=> $stable(sel_q) && $stable(en_q) && $stable(p1_dur_q) && $stable(p1_freq_q))
        else $error("write to read-only block changed state");

endmodule

`default_nettype wire

/* verilog/trip_curve_pkg.sv */
package trip_curve_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_LF_DUR_SF    = 16'h9EFE;
    localparam logic [15:0] IDX_LF_FREQ_SF   = 16'h9EFF;
    localparam logic [15:0] IDX_LF2_COUNT    = 16'h9F33;
    localparam logic [15:0] IDX_LF2_P1_DUR   = 16'h9F34;
    localparam logic [15:0] IDX_LF2_P1_FREQ  = 16'h9F35;
    localparam logic [15:0] IDX_LF2_FLAG     = 16'h9F64;
    localparam logic [15:0] IDX_LF3_COUNT    = 16'h9F65;
    localparam logic [15:0] IDX_LF3_P1_DUR   = 16'h9F66;
    localparam logic [15:0] IDX_LF3_P1_FREQ  = 16'h9F67;
    localparam logic [15:0] IDX_LF3_FLAG     = 16'h9F96;
    localparam logic [15:0] IDX_LF4_COUNT    = 16'h9F97;
    localparam logic [15:0] IDX_LF4_P1_DUR   = 16'h9F98;
    localparam logic [15:0] IDX_LF4_P1_FREQ  = 16'h9F99;
    localparam logic [15:0] IDX_LF4_FLAG     = 16'h9FC8;
    localparam logic [15:0] IDX_HF_ID        = 16'h9FC9;
    localparam logic [15:0] IDX_HF_LEN       = 16'h9FCA;
    localparam logic [15:0] IDX_HF_SEL       = 16'h9FCB;
    localparam logic [15:0] IDX_HF_EN        = 16'h9FCC;
    localparam logic [15:0] IDX_HF_DUR_SF    = 16'h9FD2;
    localparam logic [15:0] IDX_HF_FREQ_SF   = 16'h9FD3;
    localparam logic [15:0] IDX_HF_P1_DUR    = 16'h9FD6;
    localparam logic [15:0] IDX_HF_P1_FREQ   = 16'h9FD7;
    localparam logic [15:0] IDX_HF_DEF_THR   = 16'hA0D3;

    // unused curve blocks
    localparam logic [15:0] UNUSED_FIRST     = 16'h9F33;
    localparam logic [15:0] UNUSED_LAST      = 16'h9FC8;
    localparam logic [15:0] UNUSED_STRIDE    = 16'h0032;
    localparam logic [15:0] UNUSED_FLAG_OFS  = 16'h0031;
    localparam int          UNUSED_CURVES    = 3;

    // reset and fixed values
    localparam logic [15:0] RST_ZERO         = 16'h0000;
    localparam logic [15:0] VAL_READ_ONLY    = 16'h0001;
    localparam logic [15:0] VAL_MODEL_LEN    = 16'h00D2;
    localparam logic [15:0] VAL_MODEL_ID     = 16'h00A5; // arbitrary value
    localparam logic [15:0] RST_SEL          = 16'h0001;
    localparam logic [15:0] RST_EN           = 16'h0001;
    localparam logic [15:0] SF_MINUS_2       = 16'hFFFE;
    localparam logic [15:0] SF_MINUS_1       = 16'hFFFF;
    localparam logic [15:0] SF_ZERO          = 16'h0000;
    localparam logic [15:0] RST_P1_DUR       = 16'h0000;
    localparam logic [15:0] RST_P1_FREQ      = 16'h1838;
    localparam logic [15:0] RST_DEF_THR      = 16'h1770;
    localparam int          EN_BIT           = 0;

    // decade multipliers for duration scale
    localparam logic [6:0]  DEC_X1           = 7'h01;
    localparam logic [6:0]  DEC_X10          = 7'h0A;
    localparam logic [6:0]  DEC_X100         = 7'h64;

    // timing
    localparam int          CLK_PERIOD_NS    = 20;
    localparam int          DUR_UNIT_NS      = 10_000_000;
    localparam int          TRIP_MAX_MS      = 100;
    localparam int          TICK_CYCLES_DEF  = DUR_UNIT_NS / CLK_PERIOD_NS;
    localparam int          TRIP_MAX_CYC_DEF = (TRIP_MAX_MS * 1_000_000) / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        APB_SETUP  = 1'b0,
        APB_ANSWER = 1'b1
    } apb_state_type;

endpackage

/* verification/freq_trip_curve_registers_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module freq_trip_curve_registers_bench
    import trip_curve_pkg::*;
;
    logic        ref_clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] freq_meas;
    logic        offline;
    logic [31:0] r;
    logic        e;
    int          n;
    int          err_count;
    int          compares;
    logic [15:0] ro_idx [13] = '{IDX_LF2_COUNT, IDX_LF2_P1_DUR, IDX_LF2_P1_FREQ, IDX_LF2_FLAG,
        IDX_LF3_COUNT, IDX_LF3_P1_DUR, IDX_LF3_P1_FREQ, IDX_LF3_FLAG, IDX_LF4_COUNT,
        IDX_LF4_P1_DUR, IDX_LF4_P1_FREQ, IDX_LF4_FLAG, 16'h9F40};
    logic [15:0] ro_exp [13] = '{RST_ZERO, RST_ZERO, RST_ZERO, VAL_READ_ONLY, RST_ZERO,
        RST_ZERO, RST_ZERO, VAL_READ_ONLY, RST_ZERO, RST_ZERO, RST_ZERO, VAL_READ_ONLY,
        RST_ZERO};

    freq_trip_curve_registers #(.TICK_CYCLES(4), .TRIP_MAX_CYCLES(50)) dut (
        .REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FREQ_MEAS(freq_meas), .OFFLINE(offline));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [1:0] lo,
        input logic [15:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, lo};
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_count++;
            $display("CHECK FAILED pready expected 1 seen 0");
            end_sim();
        end
    endtask

    // edges from frequency step to trip, 100 when none
    task automatic trip(input logic [15:0] f);
        @(posedge ref_clk);
        freq_meas <= f;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (offline !== 1'b1 && n < 100);
        freq_meas <= 16'h0000;
        repeat (4) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_read_only();
        for (int i = 0; i < 13; i++) begin
            apb(1'b0, ro_idx[i], 2'b00, 16'h0000);
            chk("unused reset", r, {16'h0000, ro_exp[i]});
            apb(1'b1, ro_idx[i], 2'b00, 16'hFFFF);
            chk("ro write err", e, 1'b0);
            apb(1'b0, ro_idx[i], 2'b00, 16'h0000);
            chk("ro after write", r, {16'h0000, ro_exp[i]});
        end
        apb(1'b1, IDX_HF_LEN, 2'b00, 16'h0005);
        apb(1'b0, IDX_HF_LEN, 2'b00, 16'h0000);
        chk("model length", r, {16'h0000, VAL_MODEL_LEN});
        apb(1'b0, IDX_HF_SEL, 2'b00, 16'h0000);
        chk("select reset", r, {16'h0000, RST_SEL});
        apb(1'b1, IDX_HF_SEL, 2'b00, 16'h0002);
        apb(1'b0, IDX_HF_SEL, 2'b00, 16'h0000);
        chk("select range", r, {16'h0000, RST_SEL});
        apb(1'b0, IDX_HF_EN, 2'b00, 16'h0000);
        chk("enable reset", r, {16'h0000, RST_EN});
        apb(1'b0, 16'h0000, 2'b00, 16'h0000);
        chk("unmapped err", e, 1'b1);
        apb(1'b0, IDX_HF_SEL, 2'b01, 16'h0000);
        chk("misaligned err", e, 1'b1);
        $display("test read_only done");
    endtask

    task automatic test_trip_timing();
        trip(RST_P1_FREQ);
        chk("at threshold", n, 100);
        trip(RST_P1_FREQ + 16'h0001);
        chk("zero duration", n >= 1 && n <= 4, 1'b1);
        apb(1'b1, IDX_HF_P1_DUR, 2'b00, 16'h0002);
        trip(RST_P1_FREQ + 16'h0001);
        chk("no refresh yet", n >= 1 && n <= 4, 1'b1);
        apb(1'b1, IDX_HF_SEL, 2'b00, 16'h0001);
        trip(RST_P1_FREQ + 16'h0001);
        chk("two units", n >= 8 && n <= 12, 1'b1);
        apb(1'b1, IDX_HF_DUR_SF, 2'b00, SF_MINUS_1);
        apb(1'b1, IDX_HF_SEL, 2'b00, 16'h0001);
        trip(RST_P1_FREQ + 16'h0001);
        chk("scaled units", n >= 80 && n <= 84, 1'b1);
        apb(1'b1, IDX_HF_DUR_SF, 2'b00, 16'h0005);
        apb(1'b0, IDX_HF_DUR_SF, 2'b00, 16'h0000);
        chk("scale refused", r, {16'h0000, SF_MINUS_1});
        $display("test trip_timing done");
    endtask

    task automatic test_default_threshold();
        apb(1'b1, IDX_HF_SEL, 2'b00, 16'h0000);
        trip(RST_DEF_THR + 16'h0001);
        chk("select zero", n >= 1 && n <= 4, 1'b1);
        trip(RST_DEF_THR);
        chk("select zero at thr", n, 100);
        apb(1'b1, IDX_HF_SEL, 2'b00, 16'h0001);
        apb(1'b1, IDX_HF_EN, 2'b00, 16'h0002);
        trip(RST_DEF_THR + 16'h0001);
        chk("bit0 clear", n >= 1 && n <= 4, 1'b1);
        apb(1'b1, IDX_HF_EN, 2'b00, 16'h0001);
        trip(RST_DEF_THR + 16'h0001);
        chk("curve again", n, 100);
        $display("test default_threshold done");
    endtask

    task automatic test_reset();
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        apb(1'b0, IDX_HF_DUR_SF, 2'b00, 16'h0000);
        chk("scale after reset", r, {16'h0000, SF_MINUS_2});
        trip(RST_P1_FREQ + 16'h0001);
        chk("por refresh", n >= 1 && n <= 4, 1'b1);
        $display("test reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        compares = 0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        freq_meas = 16'h0000;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        test_read_only();
        test_trip_timing();
        test_default_threshold();
        test_reset();
        end_sim();
    end

endmodule

`default_nettype wire
